// ---- rtl/itsr_regs.sv ----
// itsr_regs: secondary channel data timing registers, strobe timer and observation registers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
module itsr_regs
  import itsr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // data port transfer request
  input wire logic xfer_req,
  input wire logic xfer_drive,
  output logic xfer_busy,
  output logic xfer_done,
  output logic data_strobe,
  // controller state to observe
  input wire itsr_obs_t obs_in
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] timing0;
    logic [7:0] timing1;
    itsr_obs_t obs;
    itsr_xfer_state_t xst;
    logic [4:0] cnt;
    logic drive;
    logic [3:0] rec_code;
    logic [7:0] rdata;
    logic busy;
    logic done;
    logic strobe;
  } itsr_state_t;

  itsr_state_t st;
  itsr_state_t next_st;

  function automatic logic [4:0] act_clks(input logic [2:0] code);
    act_clks = (code == 3'h0) ? ACT_ZERO_CLKS : {2'b00, code};
  endfunction : act_clks

  function automatic logic [4:0] rec_clks(input logic [3:0] code);
    rec_clks = (code == 4'h0) ? REC_ZERO_CLKS : {1'b0, code};
  endfunction : rec_clks

  logic [7:0] sel_timing;
  logic [7:0] rd_mux;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    // observation registers follow the controller every cycle
    next_st.obs = obs_in;
    // only the two timing registers take writes
    if (reg_wr && reg_addr == OFS_SEC_DRV0_TIMING) begin
      next_st.timing0 = reg_wdata & TIMING_WR_MASK;
    end
    if (reg_wr && reg_addr == OFS_SEC_DRV1_TIMING) begin
      next_st.timing1 = reg_wdata & TIMING_WR_MASK;
    end
    sel_timing = xfer_drive ? st.timing1 : st.timing0;
    // counts run on this clock, one step per cycle
    unique case (st.xst)
      ITSR_IDLE: begin
        if (xfer_req) begin
          // snapshot codes so a mid-transfer write cannot tear the cycle
          next_st.xst = ITSR_ACTIVE;
          next_st.drive = xfer_drive;
          next_st.cnt = act_clks(sel_timing[ACT_MSB:ACT_LSB]) - 5'h01;
          next_st.rec_code = sel_timing[REC_MSB:REC_LSB];
          next_st.strobe = 1'b1;
        end
      end
      ITSR_ACTIVE: begin
        if (st.cnt == 5'h00) begin
          next_st.xst = ITSR_RECOVER;
          next_st.cnt = rec_clks(st.rec_code) - 5'h01;
          next_st.strobe = 1'b0;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      ITSR_RECOVER: begin
        if (st.cnt == 5'h00) begin
          next_st.xst = ITSR_IDLE;
          next_st.done = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      default: begin
        next_st.xst = ITSR_IDLE;
        next_st.strobe = 1'b0;
      end
    endcase
    next_st.busy = (next_st.xst != ITSR_IDLE);
    // read data, valid the cycle after the strobe
    rd_mux = 8'h00;
    unique case (reg_addr)
      OFS_SEC_DRV0_TIMING: rd_mux = st.timing0 & TIMING_WR_MASK;
      OFS_SEC_DRV1_TIMING: rd_mux = st.timing1 & TIMING_WR_MASK;
      OFS_PRD_CNT_LO: rd_mux = st.obs.prd_cnt[7:0];
      OFS_PRD_CNT_HI: rd_mux = st.obs.prd_cnt[15:8];
      OFS_LAT_TIMER: rd_mux = st.obs.lat_timer;
      OFS_LAT_EXPIRE: rd_mux = st.obs.lat_expire;
      OFS_ATA_BYTE_LO: rd_mux = st.obs.ata_byte[7:0];
      OFS_ATA_BYTE_HI: rd_mux = st.obs.ata_byte[15:8];
      OFS_ATA_SECTOR: rd_mux = st.obs.ata_sector;
      OFS_ATA_BLOCK: rd_mux = st.obs.ata_block;
      OFS_PRI_DEV0_BSIZE: rd_mux = st.obs.pri_dev0_bsize;
      OFS_PRI_DEV1_BSIZE: rd_mux = st.obs.pri_dev1_bsize;
      OFS_SEC_DEV0_BSIZE: rd_mux = st.obs.sec_dev0_bsize;
      OFS_SEC_DEV1_BSIZE: rd_mux = st.obs.sec_dev1_bsize;
      default: rd_mux = 8'h00;
    endcase
    next_st.rdata = reg_rd ? rd_mux : 8'h00;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st.timing0 <= RST_TIMING;
      st.timing1 <= RST_TIMING;
      st.obs <= RST_OBS;
      st.xst <= ITSR_IDLE;
      st.cnt <= 5'h00;
      st.drive <= 1'b0;
      st.rec_code <= 4'h0;
      st.rdata <= 8'h00;
      st.busy <= 1'b0;
      st.done <= 1'b0;
      st.strobe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign xfer_busy = st.busy;
  assign xfer_done = st.done;
  assign data_strobe = st.strobe;

  // ****************************************
  // checks
  // ****************************************
  logic [4:0] chk_act_len;
  logic [4:0] chk_rec_len;
  logic [7:0] chk_timing;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chk_act_len <= 5'h00;
      chk_rec_len <= 5'h00;
      chk_timing <= 8'h00;
    end else begin
      chk_act_len <= st.strobe ? chk_act_len + 5'h01 : 5'h00;
      chk_rec_len <= (st.xst == ITSR_RECOVER) ? chk_rec_len + 5'h01 : 5'h00;
      if (st.xst == ITSR_IDLE && xfer_req) begin
        chk_timing <= xfer_drive ? st.timing1 : st.timing0;
      end
    end
  end

  property p_timing_reset;
    @(posedge clock) $past(sys_rst) |-> (st.timing0 == RST_TIMING && st.timing1 == RST_TIMING);
  endproperty
  a_timing_reset: assert property (p_timing_reset) else $error("timing registers not zero after reset");

  property p_drive_select;
    @(posedge clock) disable iff (sys_rst)
      (st.xst == ITSR_IDLE && xfer_req) |=> (st.drive == $past(xfer_drive) && data_strobe);
  endproperty
  a_drive_select: assert property (p_drive_select) else $error("transfer did not take requested drive");

  property p_active_width;
    @(posedge clock) disable iff (sys_rst)
      $fell(data_strobe) |-> chk_act_len == act_clks(chk_timing[ACT_MSB:ACT_LSB]);
  endproperty
  a_active_width: assert property (p_active_width) else $error("strobe active width wrong");

  property p_recovery_width;
    @(posedge clock) disable iff (sys_rst)
      xfer_done |-> chk_rec_len == rec_clks(chk_timing[REC_MSB:REC_LSB]);
  endproperty
  a_recovery_width: assert property (p_recovery_width) else $error("recovery time wrong");

  property p_prd_read;
    @(posedge clock) disable iff (sys_rst)
      (reg_rd && reg_addr == OFS_PRD_CNT_HI) |=> reg_rdata == $past(st.obs.prd_cnt[15:8]);
  endproperty
  a_prd_read: assert property (p_prd_read) else $error("prd counter high byte read wrong");

  property p_expire_reset;
    @(posedge clock) $past(sys_rst) |-> st.obs.lat_expire == RST_LAT_EXPIRE;
  endproperty
  a_expire_reset: assert property (p_expire_reset) else $error("expiry indicator not one after reset");

  property p_ata_byte_reset;
    @(posedge clock) $past(sys_rst) |-> st.obs.ata_byte == RST_ATA_BYTE;
  endproperty
  a_ata_byte_reset: assert property (p_ata_byte_reset) else $error("ata byte counter not two after reset");

  property p_ro_write_ignored;
    @(posedge clock) disable iff (sys_rst)
      (reg_wr && reg_addr != OFS_SEC_DRV0_TIMING && reg_addr != OFS_SEC_DRV1_TIMING)
        |=> (st.timing0 == $past(st.timing0) && st.timing1 == $past(st.timing1));
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("write to read-only offset changed state");

  property p_reserved_zero;
    @(posedge clock) disable iff (sys_rst)
      (reg_rd && (reg_addr == OFS_SEC_DRV0_TIMING || reg_addr == OFS_SEC_DRV1_TIMING)) |=> reg_rdata[7] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved timing bit read as one");

endmodule : itsr_regs

// ---- rtl/itsr_pkg.sv ----
// itsr_pkg: offsets, reset values and types of the ide timing and status register slice
package itsr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_SEC_DRV0_TIMING = 8'h5e;
  localparam logic [7:0] OFS_SEC_DRV1_TIMING = 8'h5f;
  localparam logic [7:0] OFS_PRD_CNT_LO = 8'h60;
  localparam logic [7:0] OFS_PRD_CNT_HI = 8'h61;
  localparam logic [7:0] OFS_LAT_TIMER = 8'h62;
  localparam logic [7:0] OFS_LAT_EXPIRE = 8'h63;
  localparam logic [7:0] OFS_ATA_BYTE_LO = 8'h64;
  localparam logic [7:0] OFS_ATA_BYTE_HI = 8'h65;
  localparam logic [7:0] OFS_ATA_SECTOR = 8'h66;
  localparam logic [7:0] OFS_ATA_BLOCK = 8'h67;
  localparam logic [7:0] OFS_PRI_DEV0_BSIZE = 8'h68;
  localparam logic [7:0] OFS_PRI_DEV1_BSIZE = 8'h69;
  localparam logic [7:0] OFS_SEC_DEV0_BSIZE = 8'h6a;
  localparam logic [7:0] OFS_SEC_DEV1_BSIZE = 8'h6b;

  // ****************************************
  // timing field layout and decode
  // ****************************************
  localparam int ACT_MSB = 6;
  localparam int ACT_LSB = 4;
  localparam int REC_MSB = 3;
  localparam int REC_LSB = 0;
  localparam logic [7:0] TIMING_WR_MASK = 8'h7f;
  localparam logic [4:0] ACT_ZERO_CLKS = 5'h08;
  localparam logic [4:0] REC_ZERO_CLKS = 5'h10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [15:0] RST_PRD_CNT = 16'h0000;
  localparam logic [7:0] RST_LAT_TIMER = 8'h00;
  localparam logic [7:0] RST_LAT_EXPIRE = 8'h01;
  localparam logic [15:0] RST_ATA_BYTE = 16'h0002;
  localparam logic [7:0] RST_ATA_SECTOR = 8'h00;
  localparam logic [7:0] RST_ATA_BLOCK = 8'h01;
  localparam logic [7:0] RST_BSIZE = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ITSR_IDLE = 2'b00,
    ITSR_ACTIVE = 2'b01,
    ITSR_RECOVER = 2'b10
  } itsr_xfer_state_t;

  // observed controller state, reflected read-only
  typedef struct packed {
    logic [15:0] prd_cnt;
    logic [7:0] lat_timer;
    logic [7:0] lat_expire;
    logic [15:0] ata_byte;
    logic [7:0] ata_sector;
    logic [7:0] ata_block;
    logic [7:0] pri_dev0_bsize;
    logic [7:0] pri_dev1_bsize;
    logic [7:0] sec_dev0_bsize;
    logic [7:0] sec_dev1_bsize;
  } itsr_obs_t;

  localparam itsr_obs_t RST_OBS = '{
    prd_cnt: RST_PRD_CNT, lat_timer: RST_LAT_TIMER, lat_expire: RST_LAT_EXPIRE,
    ata_byte: RST_ATA_BYTE, ata_sector: RST_ATA_SECTOR, ata_block: RST_ATA_BLOCK,
    pri_dev0_bsize: RST_BSIZE, pri_dev1_bsize: RST_BSIZE,
    sec_dev0_bsize: RST_BSIZE, sec_dev1_bsize: RST_BSIZE};

endpackage : itsr_pkg

// ---- bench/tb_itsr_regs.sv ----
// tb_itsr_regs: self-checking bench for the ide timing and status register slice
`timescale 1ns/1ns
module tb_itsr_regs
  import itsr_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic clock, sys_rst, reg_wr, reg_rd, xfer_req, xfer_drive;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, t0, t1;
  logic xfer_busy, xfer_done, data_strobe;
  itsr_obs_t obs_in;
  int fails, n_checks, seed;

  itsr_regs u_dut (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_req(xfer_req),
    .xfer_drive(xfer_drive), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
    .data_strobe(data_strobe), .obs_in(obs_in));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************************************
  // expectations and checks
  // ****************************************
  function logic [7:0] exp_byte(input logic [7:0] a);
    case (a)
      OFS_SEC_DRV0_TIMING: return t0 & 8'h7f;
      OFS_SEC_DRV1_TIMING: return t1 & 8'h7f;
      OFS_PRD_CNT_LO: return obs_in.prd_cnt[7:0];
      OFS_PRD_CNT_HI: return obs_in.prd_cnt[15:8];
      OFS_LAT_TIMER: return obs_in.lat_timer;
      OFS_LAT_EXPIRE: return obs_in.lat_expire;
      OFS_ATA_BYTE_LO: return obs_in.ata_byte[7:0];
      OFS_ATA_BYTE_HI: return obs_in.ata_byte[15:8];
      OFS_ATA_SECTOR: return obs_in.ata_sector;
      OFS_ATA_BLOCK: return obs_in.ata_block;
      OFS_PRI_DEV0_BSIZE: return obs_in.pri_dev0_bsize;
      OFS_PRI_DEV1_BSIZE: return obs_in.pri_dev1_bsize;
      OFS_SEC_DEV0_BSIZE: return obs_in.sec_dev0_bsize;
      OFS_SEC_DEV1_BSIZE: return obs_in.sec_dev1_bsize;
      default: return 8'h00;
    endcase
  endfunction : exp_byte

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // bus and transfer tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    if (a == OFS_SEC_DRV0_TIMING) t0 = d;
    if (a == OFS_SEC_DRV1_TIMING) t1 = d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= 8'($random(seed));
    #1 chk("rdata", {8'h00, reg_rdata}, {8'h00, exp_byte(a)});
  endtask : rd_chk

  task automatic xfer(input logic d);
    logic [7:0] v;
    int s;
    int n;
    int b;
    v = d ? t1 : t0;
    s = 0;
    n = 0;
    b = 0;
    @(posedge clock);
    xfer_req <= 1'b1;
    xfer_drive <= d;
    @(posedge clock);
    xfer_req <= 1'b0;
    xfer_drive <= 1'($random(seed));
    while (n < 40) begin
      #1 n++;
      if (data_strobe === 1'b1) s++;
      if (xfer_busy === 1'b1) b++;
      if (xfer_done === 1'b1) break;
      @(posedge clock);
      // second request in the second cycle, refused while busy
      xfer_req <= (n == 1);
    end
    chk("strobe", 16'(s), (v[6:4] == 3'h0) ? 16'h0008 : {13'h0000, v[6:4]});
    chk("done", 16'(n), 16'h0001 + ((v[6:4] == 3'h0) ? 16'h0008 : {13'h0000, v[6:4]})
        + ((v[3:0] == 4'h0) ? 16'h0010 : {12'h000, v[3:0]}));
    chk("busy", {15'h0000, xfer_busy}, 16'h0000);
    chk("busy_len", 16'(b), ((v[6:4] == 3'h0) ? 16'h0008 : {13'h0000, v[6:4]})
        + ((v[3:0] == 4'h0) ? 16'h0010 : {12'h000, v[3:0]}));
  endtask : xfer

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 90895;
    fails = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    xfer_req = 1'b0;
    xfer_drive = 1'b0;
    obs_in = RST_OBS;
    t0 = 8'h00;
    t1 = 8'h00;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 14; i++) rd_chk(8'h5e + 8'(i));
    repeat (6) begin
      @(posedge clock);
      obs_in <= itsr_obs_t'({$random(seed), $random(seed), $random(seed)});
      for (int i = 0; i < 14; i++) wr(8'h5e + 8'(i), 8'($random(seed)));
      wr(8'h5d, 8'($random(seed)));
      for (int i = -1; i < 15; i++) rd_chk(8'h5e + 8'(i));
    end
    for (int c = 0; c < 128; c++) begin
      wr(OFS_SEC_DRV0_TIMING, {c[0], 7'(c)});
      wr(OFS_SEC_DRV1_TIMING, {c[1], ~7'(c)});
      xfer(1'($random(seed)));
    end
    finish_test;
  end

  initial begin
    #2000000;
    fails++;
    finish_test;
  end
endmodule : tb_itsr_regs
